// ==== design/bbf_host.sv ====
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module bbf_host
#(
   parameter int ADDR_W = 17
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output bbf_pkg::bbf_pins_s FLASH_O,
   input wire logic [7:0] FLASH_DQ_I
);

   if (ADDR_W != bbf_pkg::ADDR_W) begin : g_bad_width
      $error("address width must match the pin struct");
   end

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_WAKE = 8'h02,
      ST_WSET = 8'h04,
      ST_WLOW = 8'h08,
      ST_WHIGH = 8'h10,
      ST_RSET = 8'h20,
      ST_RWAIT = 8'h40,
      ST_RDONE = 8'h80
   } bbf_state_e;

   // ------------------------------------------------------------
   // bus sequence for each operation
   // ------------------------------------------------------------
   function automatic bbf_pkg::bbf_seq_s seq_of(input bbf_pkg::bbf_op_e op,
                                                input logic [7:0] wd);
      bbf_pkg::bbf_seq_s s;
      s = '{first: wd, second: wd, first_write: 1'b1, two_writes: 1'b0, then_read: 1'b0};
      case (op)
         bbf_pkg::OP_READ: s.first_write = 1'b0;
         bbf_pkg::OP_ARRAY: s.first = bbf_pkg::CMD_READ_ARRAY;
         bbf_pkg::OP_PROGRAM:
         begin
            s.first = bbf_pkg::CMD_PROG_SETUP;
            s.two_writes = 1'b1;
         end
         bbf_pkg::OP_ERASE:
         begin
            s.first = bbf_pkg::CMD_ERASE_SETUP;
            s.second = bbf_pkg::CMD_CONFIRM;
            s.two_writes = 1'b1;
         end
         bbf_pkg::OP_STATUS:
         begin
            s.first = bbf_pkg::CMD_READ_STATUS;
            s.then_read = 1'b1;
         end
         bbf_pkg::OP_CLEAR: s.first = bbf_pkg::CMD_CLEAR_STATUS;
         bbf_pkg::OP_IDENT:
         begin
            s.first = bbf_pkg::CMD_IDENT;
            s.then_read = 1'b1;
         end
         bbf_pkg::OP_SUSPEND: s.first = bbf_pkg::CMD_SUSPEND;
         bbf_pkg::OP_RESUME: s.first = bbf_pkg::CMD_CONFIRM;
         default: s.first = wd;
      endcase
      return s;
   endfunction

   // ------------------------------------------------------------
   // data pin synchroniser
   // ------------------------------------------------------------
   logic [7:0] dq_meta_q;
   logic [7:0] dq_sync_q;

   // the flash answers asynchronously, so two flops before any use
   always_ff @(posedge CLK)
   begin
      dq_meta_q <= FLASH_DQ_I;
      dq_sync_q <= dq_meta_q;
   end

   // ------------------------------------------------------------
   // registers and sequencer state
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [3:0] op_q, op_d;
   logic pd_q, pd_d;
   logic refused_q, refused_d;
   logic supply_q, supply_d;
   logic seqerr_q, seqerr_d;
   logic [7:0] rdata_q, rdata_d;
   logic [31:0] prdata_q, prdata_d;
   bbf_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic step_q, step_d;
   bbf_pkg::bbf_seq_s seq_q, seq_d;
   bbf_pkg::bbf_pins_s pins_q, pins_d;
   logic bus_wr;
   logic bus_rd;
   logic hit;
   logic busy;
   logic start;
   bbf_pkg::bbf_op_e new_op;

   assign bus_wr = PSEL && PENABLE && PWRITE;
   assign bus_rd = PSEL && !PENABLE && !PWRITE;
   assign hit = PADDR == bbf_pkg::REG_CTRL || PADDR == bbf_pkg::REG_ADDR
             || PADDR == bbf_pkg::REG_WDATA || PADDR == bbf_pkg::REG_STATUS;
   assign busy = state_q != ST_IDLE;
   assign new_op = bbf_pkg::bbf_op_e'(PWDATA[bbf_pkg::CTRL_OP_LSB +: 4]);
   assign start = bus_wr && PADDR == bbf_pkg::REG_CTRL && !busy && !pd_q
               && PWDATA[bbf_pkg::CTRL_START_BIT];

   // register file; writes ignored while a sequence runs
   always_comb
   begin
      addr_d = addr_q;
      wdata_d = wdata_q;
      op_d = op_q;
      pd_d = pd_q;
      prdata_d = prdata_q;
      if (bus_wr && !busy)
      begin
         case (PADDR)
            bbf_pkg::REG_CTRL:
            begin
               op_d = PWDATA[bbf_pkg::CTRL_OP_LSB +: 4];
               pd_d = PWDATA[bbf_pkg::CTRL_PD_BIT];
            end
            bbf_pkg::REG_ADDR: addr_d = PWDATA[ADDR_W-1:0];
            bbf_pkg::REG_WDATA: wdata_d = PWDATA[7:0];
            default: ;
         endcase
      end
      // read data is set up in the setup cycle, so the access phase has it ready
      if (bus_rd)
      begin
         prdata_d = 32'h0000_0000;
         case (PADDR)
            bbf_pkg::REG_CTRL:
            begin
               prdata_d[bbf_pkg::CTRL_OP_LSB +: 4] = op_q;
               prdata_d[bbf_pkg::CTRL_PD_BIT] = pd_q;
            end
            bbf_pkg::REG_ADDR: prdata_d[ADDR_W-1:0] = addr_q;
            bbf_pkg::REG_WDATA: prdata_d[7:0] = wdata_q;
            bbf_pkg::REG_STATUS:
            begin
               prdata_d[bbf_pkg::STAT_BUSY_BIT] = busy || pd_q;
               prdata_d[bbf_pkg::STAT_REFUSED_BIT] = refused_q;
               prdata_d[bbf_pkg::STAT_SUPPLY_BIT] = supply_q;
               prdata_d[bbf_pkg::STAT_SEQERR_BIT] = seqerr_q;
               prdata_d[bbf_pkg::STAT_DATA_LSB +: 8] = rdata_q;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin sequencer
   // ------------------------------------------------------------
   // strobes idle high; data driven only inside write cycles
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      step_d = step_q;
      seq_d = seq_q;
      pins_d = pins_q;
      rdata_d = rdata_q;
      supply_d = supply_q;
      seqerr_d = seqerr_q;
      refused_d = refused_q;
      // software clears refused by writing one; a new refusal wins
      if (bus_wr && PADDR == bbf_pkg::REG_STATUS && PWDATA[bbf_pkg::STAT_REFUSED_BIT])
      begin
         refused_d = 1'b0;
      end
      pins_d.powerdown_n = !pd_q;
      case (state_q)
         ST_IDLE:
         begin
            pins_d.ce_n = 1'b1;
            pins_d.oe_n = 1'b1;
            pins_d.we_n = 1'b1;
            pins_d.dq_oe = 1'b0;
            if (pd_q && !pd_d)
            begin
               // leaving power-down: device restarts in array read
               state_d = ST_WAKE;
               cnt_d = bbf_pkg::CYC_WAKE;
            end
            else if (start && supply_q
                     && (new_op == bbf_pkg::OP_PROGRAM || new_op == bbf_pkg::OP_ERASE))
            begin
               refused_d = 1'b1;
            end
            else if (start)
            begin
               seq_d = seq_of(new_op, wdata_q);
               step_d = 1'b0;
               pins_d.addr = addr_q;
               if (new_op == bbf_pkg::OP_CLEAR)
               begin
                  supply_d = 1'b0;
                  seqerr_d = 1'b0;
               end
               state_d = seq_d.first_write ? ST_WSET : ST_RSET;
            end
         end
         ST_WAKE:
         begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_WSET:
         begin
            // select first, output strobe held high, data set up
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b1;
            pins_d.dq_oe = 1'b1;
            pins_d.dq_o = step_q ? seq_q.second : seq_q.first;
            state_d = ST_WLOW;
            cnt_d = bbf_pkg::CYC_WP;
         end
         ST_WLOW:
         begin
            pins_d.we_n = 1'b0;
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               state_d = ST_WHIGH;
               cnt_d = bbf_pkg::CYC_WPH;
            end
         end
         ST_WHIGH:
         begin
            // data latched on the rising write strobe, so select, address and data
            // stay one more period; releasing them with the strobe loses the command
            pins_d.we_n = 1'b1;
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h0)
            begin
               pins_d.dq_oe = 1'b0;
               pins_d.ce_n = 1'b1;
               if (seq_q.two_writes && !step_q)
               begin
                  step_d = 1'b1;
                  state_d = ST_WSET;
               end
               else if (seq_q.then_read)
               begin
                  state_d = ST_RSET;
               end
               else
               begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_RSET:
         begin
            // never drive the bus while the device may be driving it
            pins_d.dq_oe = 1'b0;
            pins_d.we_n = 1'b1;
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            state_d = ST_RWAIT;
            cnt_d = bbf_pkg::CYC_ACC;
         end
         ST_RWAIT:
         begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               rdata_d = dq_sync_q;
               if (seq_q.first == bbf_pkg::CMD_READ_STATUS && seq_q.then_read)
               begin
                  supply_d = dq_sync_q[bbf_pkg::FSR_SUPPLY_LOW];
                  seqerr_d = dq_sync_q[bbf_pkg::FSR_ERASE_FAIL]
                          && dq_sync_q[bbf_pkg::FSR_PROG_FAIL];
               end
               state_d = ST_RDONE;
               cnt_d = bbf_pkg::CYC_HZ;
            end
         end
         ST_RDONE:
         begin
            // strobes back high so the next read latches fresh status
            pins_d.ce_n = 1'b1;
            pins_d.oe_n = 1'b1;
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         addr_q <= '0;
         wdata_q <= 8'h00;
         op_q <= 4'h0;
         pd_q <= 1'b0;
         refused_q <= 1'b0;
         supply_q <= 1'b0;
         seqerr_q <= 1'b0;
         rdata_q <= 8'h00;
         prdata_q <= 32'h0000_0000;
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         step_q <= 1'b0;
         seq_q <= '0;
         pins_q <= '{addr: '0, dq_o: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                     we_n: 1'b1, powerdown_n: 1'b1};
      end
      else
      begin
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         op_q <= op_d;
         pd_q <= pd_d;
         refused_q <= refused_d;
         supply_q <= supply_d;
         seqerr_q <= seqerr_d;
         rdata_q <= rdata_d;
         prdata_q <= prdata_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         step_q <= step_d;
         seq_q <= seq_d;
         pins_q <= pins_d;
      end
   end

   // zero-wait slave; unmapped offsets answer with an error
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign PRDATA = prdata_q;
   assign FLASH_O = pins_q;

endmodule

// ==== design/bbf_pkg.sv ====
package bbf_pkg;

   // ------------------------------------------------------------
   // timing, all figures in ns, cycle counts derived (round up)
   // ------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int T_WP_NS = 40;    // write strobe low width
   localparam int T_WPH_NS = 10;   // write strobe high width
   localparam int T_ACC_NS = 150;  // read access from strobes
   localparam int T_HZ_NS = 55;    // chip select high to data float
   localparam int T_PS_NS = 480;   // power-down release to first write
   localparam int T_PWH_NS = 600;  // power-down release to first read
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] CYC_WP = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] CYC_WPH = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] CYC_ACC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
   localparam logic [3:0] CYC_HZ = 4'((T_HZ_NS + CLK_NS - 1) / CLK_NS);
   localparam int T_WAKE_NS = (T_PS_NS > T_PWH_NS) ? T_PS_NS : T_PWH_NS;
   localparam logic [3:0] CYC_WAKE = 4'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);

   // ------------------------------------------------------------
   // device command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_IDENT = 8'h90;

   // device operation_status bit positions
   localparam int FSR_READY = 7;
   localparam int FSR_ERASE_FAIL = 5;
   localparam int FSR_PROG_FAIL = 4;
   localparam int FSR_SUPPLY_LOW = 3;

   // ------------------------------------------------------------
   // controller registers on APB
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_PD_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_SUPPLY_BIT = 2;
   localparam int STAT_SEQERR_BIT = 3;
   localparam int STAT_DATA_LSB = 8;
   localparam int ADDR_W = 17;

   // operations that software can order
   typedef enum logic [3:0] {
      OP_WRITE = 4'h0,
      OP_READ = 4'h1,
      OP_ARRAY = 4'h2,
      OP_PROGRAM = 4'h3,
      OP_ERASE = 4'h4,
      OP_STATUS = 4'h5,
      OP_CLEAR = 4'h6,
      OP_IDENT = 4'h7,
      OP_SUSPEND = 4'h8,
      OP_RESUME = 4'h9
   } bbf_op_e;

   // pins driven towards the flash
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] dq_o;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic powerdown_n;
   } bbf_pins_s;

   // one bus sequence: up to two writes, optionally a read
   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      logic first_write;
      logic two_writes;
      logic then_read;
   } bbf_seq_s;

endpackage

// ==== verification/bbf_flash_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// behavioural flash device on the far side of the host pins
// ------------------------------------------------------------
module bbf_flash_model
#(
   parameter logic [7:0] MFG_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h3C  // arbitrary value
)
(
   input wire bbf_pkg::bbf_pins_s pins,
   input wire logic vpp_low,
   output logic [7:0] dq
);
   typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_IDENT} bbf_mode_e;
   bbf_mode_e mode;
   logic [7:0] mem [0:131071];
   logic [7:0] sr, sr_lat, prev_cmd, last, q;
   logic drv;
   // erased array, machine always ready, array read at power-up
   initial
   begin
      for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
      sr = 8'h80;
      mode = M_ARRAY;
      prev_cmd = 8'hFF;
      last = 8'h00;
      dq = 8'hFF;
   end
   // leaving deep power-down returns to array read
   always @(posedge pins.powerdown_n) mode = M_ARRAY;
   // status latched when the later of the two strobes falls
   always @(negedge pins.ce_n or negedge pins.oe_n)
      if (pins.ce_n === 1'b0 && pins.oe_n === 1'b0) sr_lat = sr;
   // commands taken with address and data at the rising write strobe
   always @(posedge pins.we_n)
      if (pins.ce_n === 1'b0 && pins.oe_n === 1'b1 && pins.powerdown_n === 1'b1)
         command(pins.addr, pins.dq_o);
   task automatic command(input logic [16:0] a, input logic [7:0] d);
      logic [16:0] lo, hi;
      lo = (a >= 17'h04000) ? 17'h04000 : (a >= 17'h02000) ? (a & 17'h1F000) : 17'h00000;
      hi = (a >= 17'h04000) ? 17'h1FFFF : (a >= 17'h02000) ? (lo + 17'h00FFF) : 17'h01FFF;
      if (prev_cmd == 8'h40 || prev_cmd == 8'h10)
      begin
         if (vpp_low) sr = sr | 8'h18;
         else mem[a] = mem[a] & d;
         mode = M_STATUS;
         prev_cmd = 8'h00;
      end
      else if (prev_cmd == 8'h20)
      begin
         if (d != 8'hD0) sr = sr | 8'h30;
         else if (vpp_low) sr = sr | 8'h28;
         else for (int i = lo; i <= hi; i++) mem[i] = 8'hFF;
         mode = M_STATUS;
         prev_cmd = 8'h00;
      end
      else
      begin
         prev_cmd = d;
         case (d)
            8'hFF: mode = M_ARRAY;
            8'h90: mode = M_IDENT;
            8'h50: sr = sr & 8'h80;
            8'h70, 8'h40, 8'h10, 8'h20, 8'hB0, 8'hD0: mode = M_STATUS;
            default: ;
         endcase
      end
   endtask
   // output only in a read cycle; standby, disable and power-down float
   assign drv = pins.powerdown_n === 1'b1 && pins.ce_n === 1'b0 && pins.oe_n === 1'b0
                && pins.we_n === 1'b1;
   // read source by mode; supply level plays no part in reads
   always_comb
      q = (mode == M_STATUS) ? sr_lat : (mode == M_IDENT) ? ((pins.addr == 17'h0) ? MFG_CODE :
          (pins.addr == 17'h1) ? DEV_CODE : 8'h00) : mem[pins.addr];
   // wire level: a released bus shows the inverse of its last value
   always @(pins.dq_oe or drv or pins.dq_o or q)
   begin
      if (pins.dq_oe === 1'b1) last = pins.dq_o;
      else if (drv) last = q;
      dq = (pins.dq_oe === 1'b1 || drv) ? last : ~last;
   end
endmodule

// ==== verification/bbf_host_assertions.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// pin protocol checks on the flash side of the host
// ------------------------------------------------------------
module bbf_host_assertions
#(
   parameter int ADDR_W = 17
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire bbf_pkg::bbf_pins_s FLASH_O
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   write_strobes_a:
      assert property (!FLASH_O.we_n |-> !FLASH_O.ce_n && FLASH_O.oe_n && FLASH_O.powerdown_n)
      else $error("write strobe outside a write cycle");
   write_pulse_a:
      assert property ($fell(FLASH_O.we_n) |=> FLASH_O.we_n) else $error("write pulse length");
   write_setup_a:
      assert property ($fell(FLASH_O.we_n) |-> !$past(FLASH_O.ce_n) && FLASH_O.dq_oe)
      else $error("select or data late for write");
   write_hold_a:
      assert property ($rose(FLASH_O.we_n) |-> !FLASH_O.ce_n && FLASH_O.dq_oe
         && $stable(FLASH_O.addr) && $stable(FLASH_O.dq_o)) else $error("write hold broken");
   read_strobes_a:
      assert property (!FLASH_O.oe_n |-> !FLASH_O.ce_n && FLASH_O.we_n && !FLASH_O.dq_oe)
      else $error("read cycle malformed");
   read_length_a:
      assert property ($fell(FLASH_O.oe_n) |-> (!FLASH_O.oe_n)[*5] ##1 FLASH_O.oe_n)
      else $error("read strobe length");
   read_addr_a:
      assert property ($fell(FLASH_O.oe_n) |=> ($stable(FLASH_O.addr))[*3])
      else $error("address moved in read");
   read_release_a:
      assert property ($rose(FLASH_O.oe_n) |-> FLASH_O.ce_n ##1 FLASH_O.oe_n)
      else $error("strobes not raised between reads");
   powerdown_quiet_a:
      assert property (!FLASH_O.powerdown_n |-> FLASH_O.ce_n && FLASH_O.we_n && FLASH_O.oe_n
         && !FLASH_O.dq_oe) else $error("activity in power-down");
   standby_float_a:
      assert property (FLASH_O.ce_n |-> !FLASH_O.dq_oe) else $error("host drives when deselected");
   // main scenarios reached
   cover property ($fell(FLASH_O.we_n));
   cover property ($fell(FLASH_O.oe_n));
   cover property ($rose(FLASH_O.powerdown_n));
endmodule
bind bbf_host bbf_host_assertions #(.ADDR_W(ADDR_W)) chk (.CLK(CLK), .RST(RST), .FLASH_O(FLASH_O));

// ==== verification/bbf_host_bench.sv ====
`timescale 1ns/10ps
module bbf_host_bench;
   localparam logic [7:0] MFG = 8'h5E; // arbitrary value
   localparam logic [7:0] DEV = 8'hC3; // arbitrary value
   logic clk, rst, psel, penable, pwrite, pready, pslverr, vpp_low, slverr;
   logic [7:0] paddr, dq;
   logic [31:0] pwdata, prdata, rd;
   bbf_pkg::bbf_pins_s flash_o;
   int err_total, n_compared;
   bbf_host uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FLASH_O(flash_o), .FLASH_DQ_I(dq));
   bbf_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) flash (.pins(flash_o), .vpp_low(vpp_low),
      .dq(dq));
   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin err_total++; report_and_stop(); end
      @(posedge clk);
   endtask
   // poll busy with a bound; the last status word stays in rd
   task automatic wait_idle();
      int n;
      n = 0;
      do begin xfer(bbf_pkg::REG_STATUS, 1'b0, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) begin err_total++; report_and_stop(); end
   endtask
   task automatic run_op(input bbf_pkg::bbf_op_e op, input logic [16:0] a, input logic [7:0] d);
      xfer(bbf_pkg::REG_ADDR, 1'b1, {15'h0, a});
      xfer(bbf_pkg::REG_WDATA, 1'b1, {24'h0, d});
      xfer(bbf_pkg::REG_CTRL, 1'b1, {27'h0, op, 1'b1});
      wait_idle();
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, vpp_low} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      n_compared = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      xfer(bbf_pkg::REG_STATUS, 1'b0, 32'h0);
      check("status after reset", rd, 32'h0);
      xfer(8'h40, 1'b0, 32'h0);
      check("unmapped error", {31'h0, slverr}, 32'h1);
      run_op(bbf_pkg::OP_READ, 17'h00005, 8'h00);
      check("array after power-up", rd[15:8], 8'hFF);
      run_op(bbf_pkg::OP_PROGRAM, 17'h12345, 8'h5A);
      run_op(bbf_pkg::OP_PROGRAM, 17'h00010, 8'h33);
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("status after program", rd[15:8], 8'h80);
      run_op(bbf_pkg::OP_ARRAY, 17'h1FFFF, 8'h00);
      run_op(bbf_pkg::OP_READ, 17'h12345, 8'h00);
      check("programmed byte", rd[15:8], 8'h5A);
      run_op(bbf_pkg::OP_IDENT, 17'h0, 8'h00);
      check("maker code", rd[15:8], MFG);
      run_op(bbf_pkg::OP_IDENT, 17'h1, 8'h00);
      check("device code", rd[15:8], DEV);
      run_op(bbf_pkg::OP_READ, 17'h1, 8'h00);
      check("identifier held", rd[15:8], DEV);
      // erase setup followed by the wrong command
      run_op(bbf_pkg::OP_WRITE, 17'h12345, 8'h20);
      run_op(bbf_pkg::OP_WRITE, 17'h12345, 8'hFF);
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("bad sequence flags", rd[15:8], 8'hB0);
      check("sequence error bit", rd[3], 1'b1);
      run_op(bbf_pkg::OP_READ, 17'h12345, 8'h00);
      check("status mode held", rd[15:8], 8'hB0);
      run_op(bbf_pkg::OP_CLEAR, 17'h0, 8'h00);
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("flags cleared", rd[15:8], 8'h80);
      run_op(bbf_pkg::OP_ERASE, 17'h12345, 8'h00);
      run_op(bbf_pkg::OP_ARRAY, 17'h0, 8'h00);
      run_op(bbf_pkg::OP_READ, 17'h12345, 8'h00);
      check("erased byte", rd[15:8], 8'hFF);
      run_op(bbf_pkg::OP_READ, 17'h00010, 8'h00);
      check("other block kept", rd[15:8], 8'h33);
      run_op(bbf_pkg::OP_SUSPEND, 17'h0ABCD, 8'h00);
      run_op(bbf_pkg::OP_RESUME, 17'h1FFFF, 8'h00);
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("suspend resume status", rd[15:8], 8'h80);
      // low program supply
      vpp_low <= 1'b1;
      run_op(bbf_pkg::OP_PROGRAM, 17'h00020, 8'h00);
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("supply low flags", rd[15:8], 8'h98);
      check("supply low seen", rd[2], 1'b1);
      run_op(bbf_pkg::OP_ARRAY, 17'h0, 8'h00);
      run_op(bbf_pkg::OP_READ, 17'h00020, 8'h00);
      check("read with low supply", rd[15:8], 8'hFF);
      run_op(bbf_pkg::OP_ERASE, 17'h12345, 8'h00);
      check("erase refused", rd[1], 1'b1);
      run_op(bbf_pkg::OP_CLEAR, 17'h0, 8'h00);
      vpp_low <= 1'b0;
      run_op(bbf_pkg::OP_STATUS, 17'h0, 8'h00);
      check("supply flag cleared", rd[15:8], 8'h80);
      // power-down from status mode, then array read on wake
      xfer(bbf_pkg::REG_CTRL, 1'b1, 32'h100);
      // the pin follows the register one edge later; look once it has settled
      @(negedge clk);
      check("powerdown pin", flash_o.powerdown_n, 1'b0);
      @(posedge clk);
      xfer(bbf_pkg::REG_CTRL, 1'b1, 32'h0);
      wait_idle();
      run_op(bbf_pkg::OP_READ, 17'h00010, 8'h00);
      check("array after wake", rd[15:8], 8'h33);
      report_and_stop();
   end
endmodule
